// File: src/urx_pkg.sv
//==============================================================
// Purpose: constants and carrier types for the serial port block
// Assumes: 32-bit AXI4-Lite register window, one word per register
// Notes:   offsets are byte addresses
package urx_pkg;
	//==========================================================
	// register offsets
	localparam logic [7:0] OFS_DATA   = 8'h00; // serial_data_port
	localparam logic [7:0] OFS_CSA    = 8'h04; // ctrl_status_a
	localparam logic [7:0] OFS_CSB    = 8'h08; // enables, size msb, ninth bits
	localparam logic [7:0] OFS_CSC    = 8'h0C; // frame format
	localparam logic [7:0] OFS_BAUD   = 8'h10; // sample tick divisor
	//==========================================================
	// ctrl_status_a fields
	localparam int CSA_RXC  = 7; // receive complete
	localparam int CSA_TXC  = 6; // transmit complete, write one clears
	localparam int CSA_TBE  = 5; // tx_buffer_empty_flag
	localparam int CSA_FE   = 4; // frame error of oldest entry
	localparam int CSA_DOR  = 3; // overrun
	localparam int CSA_DBL  = 1; // double_speed_select
	localparam int CSA_AFE  = 0; // address_filter_enable
	// ctrl_status_b fields
	localparam int CSB_RXEN = 4; // receiver enable
	localparam int CSB_TXEN = 3; // transmitter enable
	localparam int CSB_SZ2  = 2; // char_size_code msb
	localparam int CSB_RX9  = 1; // rx_ninth_bit, read only
	localparam int CSB_TX9  = 0; // tx_ninth_bit
	// ctrl_status_c fields
	localparam int CSC_EXT  = 6; // extended_biphase_mode
	localparam int CSC_TWO  = 3; // two_stop_select
	localparam int CSC_SZ0  = 1; // char_size_code low pair lsb
	//==========================================================
	// reset values
	localparam logic [2:0]  SIZE_RST = 3'h3;      // eight data bits
	localparam logic [11:0] BAUD_RST = 12'h000_C; // plain default
	localparam logic [2:0]  SIZE_NINE = 3'h7;     // nine data bits code
	localparam logic [3:0]  BITS_BASE = 4'h5;     // bits for code zero
	localparam logic [3:0]  BITS_NINE = 4'h9;
	localparam logic [3:0]  BITS_EIGHT = 4'h8;
	//==========================================================
	// sampling figures
	localparam logic [4:0] SPB_NORM   = 5'h10; // samples per bit, normal
	localparam logic [4:0] SPB_DBL    = 5'h08; // samples per bit, double
	localparam logic [4:0] VFIRST_NRM = 5'h08; // first vote sample
	localparam logic [4:0] VFIRST_DBL = 5'h04;
	localparam logic [4:0] VMID_NRM   = 5'h09; // middle vote sample
	localparam logic [4:0] VMID_DBL   = 5'h05;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;  // receive buffer entries
	//==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	//==========================================================
	// carriers
	typedef struct packed {
		logic       fe;    // stop bit read low
		logic       ninth; // received ninth bit
		logic [7:0] data;  // low data bits, unused bits zero
	} urx_entry_t;
	typedef struct packed {
		logic       afe;   // address_filter_enable
		logic       dbl;   // double_speed_select
		logic       rx_en;
		logic       tx_en;
		logic [2:0] size;  // char_size_code
		logic       two;   // two_stop_select
		logic       ext;   // extended_biphase_mode
		logic       tx9;   // tx_ninth_bit
	} urx_cfg_t;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b11,
		RX_STOP  = 2'b10
	} urx_rx_st_t;
endpackage : urx_pkg

// File: src/urx_pin_sync.sv
//==============================================================
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pin is asynchronous to aclk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/10ps
module urx_pin_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin,
	output logic      level
);
	logic s1_q; // first stage, read only by s2
	logic s2_q;
	logic s3_q;
	//==========================================================
	// stage chain
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// agreement filter, one-cycle glitches never reach the output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level <= RST_VAL;
		end else if (s2_q == s3_q) begin
			level <= s3_q;
		end
	end
endmodule : urx_pin_sync

// File: src/urx_top.sv
//==============================================================
// Purpose: async serial port with voting receiver and address filter
// Assumes: AXI4-Lite slave on aclk, one write and one read at a time
// Notes:   sample tick from a shared divider, no parity logic
// Contract
// - sixteen samples per bit, eight double
// - first vote sample eight, or four
// - middle vote sample nine, or five
// - normal speed accepts 95.36 to 104.58 percent
// - double speed accepts 96.00 to 103.90 percent
// - filtering only outside extended biphase mode
// - filtering drops data frames
// - transmitter ignores filter setting
// - five to eight bits: stop bit types
// - nine bits: ninth bit types frame
// - type one address, zero data
// - address frames stored, flag set normally
// - one size setting for both directions
// - one data port, write tx, read rx
// - unused upper bits ignored, read zero
// - write while buffer full is dropped
// - buffer moves to idle shifter, shifts out
// - two-entry receive fifo, read pops oldest
// - majority of three centre samples
// - double speed divides by eight
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module urx_top import urx_pkg::*; #(
	parameter int DIV_W = 12 // divisor width
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin
);
	if (DIV_W < 1 || DIV_W > 12) begin : g_bad_div
		$error("DIV_W must be 1 to 12");
	end
	//==========================================================
	// declarations
	urx_cfg_t         cfg_q;        // software settings
	logic [DIV_W-1:0] baud_q;       // divisor minus one
	logic [DIV_W-1:0] pre_q;        // divider counter
	logic             tick;         // one sample period
	logic [4:0]       spb;          // samples per bit
	logic [4:0]       vfirst;       // first vote sample
	logic [4:0]       vmid;         // middle vote sample
	logic [3:0]       nbits;        // data bits per frame
	logic             rx_line;      // filtered pin level
	urx_rx_st_t       rx_st_q;
	logic [4:0]       rx_smp_q;     // sample number in bit
	logic [3:0]       rx_idx_q;     // data bit index
	logic [1:0]       rx_v_q;       // first two vote samples
	logic [8:0]       rx_sh_q;      // assembled bits
	logic             vote;         // majority result
	logic             rx_done;      // stop bit voted
	logic             ftype;        // frame type bit
	logic             keep;         // frame goes to fifo
	urx_entry_t       mem_q [2];    // receive fifo
	logic             head_q;       // oldest entry index
	logic [1:0]       cnt_q;        // entries held
	logic             pop;
	logic             push;
	logic             dor_q;        // overrun seen
	logic [8:0]       txb_q;        // tx_buffer_reg
	logic             txb_v_q;      // buffer full
	logic             tx_busy_q;
	logic [11:0]      tx_sh_q;      // frame shift register
	logic [3:0]       tx_left_q;    // bits still to send
	logic [4:0]       tx_smp_q;
	logic             txc_q;        // transmit complete
	logic [11:0]      tx_frame;
	logic             aw_q;         // write address held
	logic             w_q;          // write data held
	logic [7:0]       awa_q;
	logic [31:0]      wd_q;
	logic [3:0]       ws_q;
	logic             wr_go;        // both halves present
	logic             wr_data;      // data port written
	logic             rd_go;
	logic [31:0]      rd_val;
	logic             rd_ok;
	//==========================================================
	// pin input
	urx_pin_sync #(
		.RST_VAL (1'b1)
	) u_rx_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (serial_in_pin),
		.level   (rx_line)
	);
	//==========================================================
	// frame shape, shared by both directions
	always_comb begin
		spb    = cfg_q.dbl ? SPB_DBL : SPB_NORM;
		vfirst = cfg_q.dbl ? VFIRST_DBL : VFIRST_NRM;
		vmid   = cfg_q.dbl ? VMID_DBL : VMID_NRM;
		// one size code serves receiver and transmitter
		if (cfg_q.size == SIZE_NINE) begin
			nbits = BITS_NINE;
		end else if (cfg_q.size[2]) begin
			nbits = BITS_EIGHT;                        // unused codes
		end else begin
			nbits = BITS_BASE + {2'b00, cfg_q.size[1:0]};
		end
	end
	// sample tick divider, runs free so both directions stay aligned
	always_ff @(posedge aclk) begin
		if (!aresetn || pre_q == '0) begin
			pre_q <= baud_q;
		end else begin
			pre_q <= pre_q - 1'b1;
		end
	end
	assign tick = (pre_q == '0);
	//==========================================================
	// receiver: voting and bit assembly
	// vote on the third sample, taken live from the line
	assign vote = (rx_v_q[0] & rx_v_q[1]) | (rx_v_q[0] & rx_line)
	            | (rx_v_q[1] & rx_line);
	assign rx_done = tick && rx_st_q == RX_STOP && rx_smp_q == vmid + 5'h01;
	// frame type: ninth bit in nine-bit frames, else the stop bit
	assign ftype = (nbits == BITS_NINE) ? rx_sh_q[8] : vote;
	// filter only drops type zero, and only in standard mode
	assign keep = !(cfg_q.afe && !cfg_q.ext) || ftype;
	// bit timing: voting ends before the bit does, so an early
	// start edge after the stop vote is still caught
	always_ff @(posedge aclk) begin
		if (!aresetn || !cfg_q.rx_en) begin
			rx_st_q  <= RX_IDLE;
			rx_smp_q <= 5'h01;
			rx_idx_q <= '0;
			rx_v_q   <= '0;
			rx_sh_q  <= '0;
		end else if (tick) begin
			rx_smp_q <= (rx_smp_q == spb) ? 5'h01 : rx_smp_q + 5'h01;
			if (rx_smp_q == vfirst) begin
				rx_v_q[0] <= rx_line;
			end
			if (rx_smp_q == vmid) begin
				rx_v_q[1] <= rx_line;
			end
			unique case (rx_st_q)
				RX_IDLE: begin
					// this tick is sample one of the start bit
					rx_smp_q <= 5'h02;
					rx_sh_q  <= '0;
					if (!rx_line) begin
						rx_st_q <= RX_START;
					end
				end
				RX_START: begin
					// a high vote is a noise spike
					if (rx_smp_q == vmid + 5'h01 && vote) begin
						rx_st_q <= RX_IDLE;
					end else if (rx_smp_q == spb) begin
						rx_st_q  <= RX_DATA;
						rx_idx_q <= '0;
					end
				end
				RX_DATA: begin
					if (rx_smp_q == vmid + 5'h01) begin
						rx_sh_q[rx_idx_q] <= vote;
					end
					if (rx_smp_q == spb) begin
						if (rx_idx_q == nbits - 4'h1) begin
							rx_st_q <= RX_STOP;
						end
						rx_idx_q <= rx_idx_q + 4'h1;
					end
				end
				RX_STOP: begin
					// only the first stop bit is looked at
					if (rx_smp_q == vmid + 5'h01) begin
						rx_st_q <= RX_IDLE;
					end
				end
			endcase
		end
	end
	//==========================================================
	// receive fifo
	assign push = rx_done && keep && (cnt_q != FIFO_DEPTH || pop);
	always_ff @(posedge aclk) begin
		if (!aresetn || !cfg_q.rx_en) begin
			head_q <= 1'b0;
			cnt_q  <= '0;
		end else begin
			// a read of the data port while an entry is held moves the fifo on
			if (pop) begin
				head_q <= ~head_q;
			end
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
	// entry store, written at the slot behind the oldest
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else if (push) begin
			mem_q[head_q ^ cnt_q[0]].data  <= rx_sh_q[7:0];
			mem_q[head_q ^ cnt_q[0]].ninth <= rx_sh_q[8];
			mem_q[head_q ^ cnt_q[0]].fe    <= ~vote;
		end
	end
	// overrun: a kept frame with no room is lost; set beats clear
	always_ff @(posedge aclk) begin
		if (!aresetn || !cfg_q.rx_en) begin
			dor_q <= 1'b0;
		end else if (rx_done && keep && !push) begin
			dor_q <= 1'b1;
		end else if (pop) begin
			dor_q <= 1'b0;
		end
	end
	//==========================================================
	// transmitter, unaware of the filter setting
	always_comb begin
		tx_frame    = '1;
		tx_frame[0] = 1'b0; // start bit
		for (int i = 0; i < 9; i++) begin
			if (i < int'(nbits)) begin
				tx_frame[i+1] = txb_q[i];
			end
		end
	end
	// buffer: a write while full is simply not taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txb_v_q <= 1'b0;
			txb_q   <= '0;
		end else if (wr_data && !txb_v_q) begin
			txb_v_q <= 1'b1;
			txb_q   <= {cfg_q.tx9, wd_q[7:0]};
		end else if (cfg_q.tx_en && !tx_busy_q) begin
			txb_v_q <= 1'b0;
		end
	end
	// shifter: loads from the buffer whenever it is empty and tx_en is set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_busy_q <= 1'b0;
			tx_sh_q   <= '1;
			tx_left_q <= '0;
			tx_smp_q  <= '0;
		end else if (!tx_busy_q) begin
			if (cfg_q.tx_en && txb_v_q) begin
				tx_busy_q <= 1'b1;
				tx_sh_q   <= tx_frame;
				tx_left_q <= nbits + (cfg_q.two ? 4'h3 : 4'h2);
				tx_smp_q  <= '0;
			end
		end else if (tick) begin
			// each bit lasts one full set of samples
			if (tx_smp_q == spb - 5'h01) begin
				tx_smp_q  <= '0;
				tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
				tx_left_q <= tx_left_q - 4'h1;
				if (tx_left_q == 4'h1) begin
					tx_busy_q <= 1'b0;
				end
			end else begin
				tx_smp_q <= tx_smp_q + 5'h01;
			end
		end
	end
	// line driver from a flop, idles high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_out_pin <= 1'b1;
		end else begin
			serial_out_pin <= tx_busy_q ? tx_sh_q[0] : 1'b1;
		end
	end
	// transmit complete: set beats a write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txc_q <= 1'b0;
		end else if (tx_busy_q && tick && tx_left_q == 4'h1
		             && tx_smp_q == spb - 5'h01 && !txb_v_q) begin
			txc_q <= 1'b1;
		end else if (wr_go && awa_q == OFS_CSA && ws_q[0] && wd_q[CSA_TXC]) begin
			txc_q <= 1'b0;
		end
	end
	//==========================================================
	// axi write channel: halves taken in either order
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;
	assign wr_go   = aw_q && w_q && !s_axi_bvalid;
	assign wr_data = wr_go && awa_q == OFS_DATA && ws_q[0];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q  <= 1'b0;
			w_q   <= 1'b0;
			awa_q <= '0;
			wd_q  <= '0;
			ws_q  <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q  <= 1'b1;
				awa_q <= {s_axi_awaddr[7:2], 2'b00};
			end else if (wr_go) begin
				aw_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q  <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_q <= 1'b0;
			end
		end
	end
	// write response, unmapped offsets answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awa_q > OFS_BAUD) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	// settings, byte lane zero carries every control bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q      <= '0;
			cfg_q.size <= SIZE_RST;
			baud_q     <= DIV_W'(BAUD_RST);
		end else if (wr_go && ws_q[0]) begin
			unique case (awa_q)
				OFS_CSA: begin
					cfg_q.dbl <= wd_q[CSA_DBL];
					cfg_q.afe <= wd_q[CSA_AFE];
				end
				OFS_CSB: begin
					cfg_q.rx_en   <= wd_q[CSB_RXEN];
					cfg_q.tx_en   <= wd_q[CSB_TXEN];
					cfg_q.size[2] <= wd_q[CSB_SZ2];
					cfg_q.tx9     <= wd_q[CSB_TX9];
				end
				OFS_CSC: begin
					cfg_q.ext       <= wd_q[CSC_EXT];
					cfg_q.two       <= wd_q[CSC_TWO];
					cfg_q.size[1:0] <= wd_q[CSC_SZ0 +: 2];
				end
				OFS_BAUD: begin
					baud_q <= wd_q[DIV_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end
	//==========================================================
	// axi read channel, a data port read pops the fifo
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign pop   = rd_go && s_axi_araddr[7:2] == OFS_DATA[7:2] && cnt_q != '0;
	always_comb begin
		rd_val = '0;
		rd_ok  = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'b00})
			OFS_DATA: begin
				rd_val[7:0] = (cnt_q != '0) ? mem_q[head_q].data : 8'h00;
			end
			OFS_CSA: begin
				rd_val[CSA_RXC] = cnt_q != '0;
				rd_val[CSA_TXC] = txc_q;
				rd_val[CSA_TBE] = !txb_v_q;
				rd_val[CSA_FE]  = (cnt_q != '0) && mem_q[head_q].fe;
				rd_val[CSA_DOR] = dor_q;
				rd_val[CSA_DBL] = cfg_q.dbl;
				rd_val[CSA_AFE] = cfg_q.afe;
			end
			OFS_CSB: begin
				rd_val[CSB_RXEN] = cfg_q.rx_en;
				rd_val[CSB_TXEN] = cfg_q.tx_en;
				rd_val[CSB_SZ2]  = cfg_q.size[2];
				rd_val[CSB_RX9]  = (cnt_q != '0) && mem_q[head_q].ninth;
				rd_val[CSB_TX9]  = cfg_q.tx9;
			end
			OFS_CSC: begin
				rd_val[CSC_EXT]        = cfg_q.ext;
				rd_val[CSC_TWO]        = cfg_q.two;
				rd_val[CSC_SZ0 +: 2]   = cfg_q.size[1:0];
			end
			OFS_BAUD: begin
				rd_val[DIV_W-1:0] = baud_q;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end
	// read answer registered one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : urx_top

// File: test/urx_top_sva.sv
//==============================================================
// Purpose: bus and line timing checks on the serial port top
// Assumes: bound to urx_top, one aclk domain
// Notes:   sees top ports only
`timescale 1ns/10ps
module urx_top_sva import urx_pkg::*; (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        serial_out_pin
);
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [7:0] ar_q; // offset of the read in flight
	//==========================================================
	// read offset tracker, reset so a stale offset never leaks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_q <= 8'h00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			ar_q <= s_axi_araddr;
		end
	end
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	//==========================================================
	// checks
	a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
		else $error("write answer missing");
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_b_blocks_aw: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during answer");
	a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read answer missing");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed");
	a_r_blocks_ar: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during answer");
	a_unmapped_err: assert property (s_rd_take ##0 (s_axi_araddr > 8'h13)
		|=> s_axi_rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
	a_data_upper: assert property (s_axi_rvalid && ar_q == OFS_DATA |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("data read upper bits set");
	a_start_len: assert property ($fell(serial_out_pin) |=> !serial_out_pin [*7])
		else $error("start bit too short");
endmodule : urx_top_sva

// File: test/urx_far_node.sv
//==============================================================
// Purpose: far serial node, sends and captures frames
// Assumes: line idles high, bit times in ns
// Notes:   behavioural, free of aclk on purpose
`timescale 1ns/10ps
module urx_far_node (
	output logic      line_out,
	input  wire logic line_in
);
	initial line_out = 1'b1; // idle high
	//==========================================================
	// start, n bits lsb first, type stop, second stop
	task automatic send(input logic [8:0] d, input int n, input logic s1, input realtime bt);
		line_out = 1'b0;
		#bt;
		for (int i = 0; i < n; i++) begin
			line_out = d[i]; // ninth bit one marks address
			#bt;
		end
		line_out = s1; // first stop carries the type
		#bt;
		line_out = 1'b1;
		#bt;
	endtask : send
	//==========================================================
	// capture one frame at bit centres
	task automatic recv(input int n, input realtime bt, output logic [8:0] d, output logic st);
		d = 9'h000;
		@(negedge line_in);
		#(bt * 1.5);
		for (int i = 0; i < n; i++) begin
			d[i] = line_in;
			#bt;
		end
		st = line_in;
	endtask : recv
endmodule : urx_far_node

// File: test/urx_top_tb.sv
//==============================================================
// Purpose: register-level tests of the serial port block
// Assumes: baud 0 gives 16 aclk per bit
// Notes:   far node drives the receive line
`timescale 1ns/10ps
module urx_top_tb import urx_pkg::*; ;
	localparam realtime BT = 640.0; // nominal bit, zero error
	realtime     tol[4] = '{6700.0, 6135.0, 3328.0, 3086.0}; // near limits
	logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic        rx_line, tx_line, fs[2];
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [1:0]  bresp, rresp, wresp; // wresp: last write answer
	logic [8:0]  fd[2];
	int          mismatches = 0, checks_done = 0;
	urx_top i_urx_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .serial_in_pin(rx_line), .serial_out_pin(tx_line));
	urx_far_node i_urx_far_node (.line_out(rx_line), .line_in(tx_line));
	initial begin
		forever #20 aclk = ~aclk;
	end
	//==========================================================
	// report and close
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	//==========================================================
	// bus tasks: ready sampled at negedge, acted on at next posedge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		@(posedge aclk);
		{aw, w, b} = 3'b111;
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'b111;
		while (b) begin
			@(negedge aclk);
			aw = aw && !awready;
			w = w && !wready;
			b = !bvalid;
			wresp = bresp;
			@(posedge aclk);
			{awvalid, wvalid, bready} <= {aw, w, b};
		end
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ar, rr;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		{ar, rr} = 2'b11;
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		while (rr) begin
			@(negedge aclk);
			ar = ar && !arready;
			rr = !rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			{arvalid, rready} <= {ar, rr};
		end
		chk({30'h0, r}, {30'h0, er});
		chk(d, e);
	endtask : rdc
	//==========================================================
	// data frame then address frame, two reads expected
	task automatic pair(input logic [31:0] b, c, a, input int n, input logic [31:0] e0, e1);
		wr(OFS_CSB, b);
		wr(OFS_CSC, c);
		wr(OFS_CSA, a);
		i_urx_far_node.send(9'h03C, n, n == 9, BT);
		i_urx_far_node.send(9'h1C3, n, 1'b1, BT);
		if (n == 9) begin
			rdc(OFS_CSB, b | (e0 == 32'h0000_00C3 ? 32'h0000_0002 : 32'h0000_0000), RESP_OKAY);
		end
		rdc(OFS_DATA, e0, RESP_OKAY);
		rdc(OFS_DATA, e1, RESP_OKAY);
		$display("test frame type done");
	endtask : pair
	initial begin
		repeat (60000) @(posedge aclk);
		mismatches++;
		end_sim();
	end
	//==========================================================
	// main sequence
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(OFS_CSA, 32'h0000_0020, RESP_OKAY);
		rdc(OFS_CSC, 32'h0000_0006, RESP_OKAY);
		rdc(8'h20, 32'h0000_0000, RESP_SLVERR);
		wr(8'h20, 32'h0000_0000);
		chk({30'h0, wresp}, {30'h0, RESP_SLVERR});
		wr(OFS_BAUD, 32'h0000_0000);
		chk({30'h0, wresp}, {30'h0, RESP_OKAY});
		wr(OFS_CSB, 32'h0000_0018);
		i_urx_far_node.send(9'h0A5, 8, 1'b1, BT);
		i_urx_far_node.send(9'h05A, 8, 1'b1, BT);
		rdc(OFS_CSA, 32'h0000_00A0, RESP_OKAY);
		rdc(OFS_DATA, 32'h0000_00A5, RESP_OKAY);
		rdc(OFS_DATA, 32'h0000_005A, RESP_OKAY);
		rdc(OFS_CSA, 32'h0000_0020, RESP_OKAY);
		$display("test fifo done");
		pair(32'h0000_0018, 32'h0000_0006, 32'h0000_0001, 8, 32'h0000_00C3, 32'h0000_0000);
		pair(32'h0000_001C, 32'h0000_0006, 32'h0000_0001, 9, 32'h0000_00C3, 32'h0000_0000);
		pair(32'h0000_001C, 32'h0000_0006, 32'h0000_0000, 9, 32'h0000_003C, 32'h0000_00C3);
		pair(32'h0000_0018, 32'h0000_0046, 32'h0000_0001, 8, 32'h0000_003C, 32'h0000_00C3);
		wr(OFS_CSC, 32'h0000_0000);
		i_urx_far_node.send(9'h1FF, 5, 1'b1, BT);
		rdc(OFS_DATA, 32'h0000_001F, RESP_OKAY);
		fork
			i_urx_far_node.recv(5, BT, fd[0], fs[0]);
			wr(OFS_DATA, 32'h0000_00D5);
		join
		chk({22'h0, fd[0], fs[0]}, {22'h0, 9'h015, 1'b1});
		// let the stop bit finish so tx complete is set before it is read
		repeat (16) @(posedge aclk);
		rdc(OFS_CSA, 32'h0000_0061, RESP_OKAY);
		$display("test short size done");
		wr(OFS_CSC, 32'h0000_0006);
		for (int s = 0; s < 2; s++) begin
			wr(OFS_CSA, 32'h0000_0041 | 32'(s << 1));
			fork
				begin
					i_urx_far_node.recv(8, BT / (s + 1), fd[0], fs[0]);
					i_urx_far_node.recv(8, BT / (s + 1), fd[1], fs[1]);
				end
				begin
					wr(OFS_DATA, 32'h0000_0081);
					wr(OFS_DATA, 32'h0000_0042);
					rdc(OFS_CSA, 32'h0000_0001 | 32'(s << 1), RESP_OKAY);
					wr(OFS_DATA, 32'h0000_0024);
				end
			join
			repeat (16) @(posedge aclk);
			chk({14'h0, fd[0], fd[1]}, {14'h0, 9'h081, 9'h042});
			rdc(OFS_CSA, 32'h0000_0061 | 32'(s << 1), RESP_OKAY);
			$display("test transmit done");
		end
		wr(OFS_BAUD, 32'h0000_0009);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CSA, 32'h0000_0040 | 32'((i / 2) << 1));
			i_urx_far_node.send(9'h0AA, 8, 1'b1, tol[i]);
			rdc(OFS_CSA, 32'h0000_00A0 | 32'((i / 2) << 1), RESP_OKAY);
			rdc(OFS_DATA, 32'h0000_00AA, RESP_OKAY);
		end
		$display("test rate tolerance done");
		end_sim();
	end
endmodule : urx_top_tb
bind urx_top urx_top_sva i_urx_top_sva (.*);
